/* File: core/lfs_interface_module.sv */
// Purpose: loopback selection and fault relay / open-collector status outputs
// Assumes: control processor writes loopback and fault words over the register port
// Notes:   faults held asserted from reset until the processor clears them
//
// Notes on behaviour
// RQ1: tx loopback sends line tx data to rx drivers
// RQ2: rx loopback retransmits satellite data
// RQ3: combined selection applies both loopbacks
// RQ4: three relays set by processor fault word
// RQ5: modulator relay drops on tx fault
// RQ6: demodulator relay drops on rx fault
// RQ7: common relay drops on common fault
// RQ8: modulator line sinks unless tx/common fault
// RQ9: demodulator line sinks unless rx/common fault
// RQ10: outputs show fault until processor clears
// RQ11: processor picks one of four loopbacks

`timescale 1ns/10ps
`default_nettype none

module lfs_interface_module #(
    parameter int DW = 1
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic [lfs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [lfs_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [lfs_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [DW-1:0]             terr_tx_data,
    input  wire logic [DW-1:0]             sat_rx_data,
    output logic      [DW-1:0]             bb_tx_data,
    output logic      [DW-1:0]             terr_rx_data,
    output logic                           relay_mod,
    output logic                           relay_demod,
    output logic                           relay_common,
    input  wire logic                      oc_mod_in,
    output logic                           oc_mod_out,
    output logic                           oc_mod_oe,
    input  wire logic                      oc_demod_in,
    output logic                           oc_demod_out,
    output logic                           oc_demod_oe,
    output logic                           irq
);

    lfs_pkg::lfs_state_s st_ff;
    lfs_pkg::lfs_state_s nxt_st;

    logic                       wr_ctrl;
    logic                       wr_fault;
    logic                       wr_istat;
    logic                       wr_imask;
    logic [lfs_pkg::INT_W-1:0]  evt;
    logic [lfs_pkg::INT_W-1:0]  clr;
    logic                       f_tx;
    logic                       f_rx;
    logic                       f_cmn;

    // ==========================================================
    // register and status logic
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = '0;
        wr_ctrl      = reg_wr && (reg_addr == lfs_pkg::ADDR_CTRL);
        wr_fault     = reg_wr && (reg_addr == lfs_pkg::ADDR_FAULT);
        wr_istat     = reg_wr && (reg_addr == lfs_pkg::ADDR_INT_STAT);
        wr_imask     = reg_wr && (reg_addr == lfs_pkg::ADDR_INT_MASK);

        // RQ11: two-bit loopback field
        if (wr_ctrl) begin
            nxt_st.lbm = lfs_pkg::lfs_lbm_e'(reg_wdata[lfs_pkg::CTRL_LBM_POS +: 2]);
        end
        // RQ4: processor fault word
        if (wr_fault) begin
            nxt_st.flt = reg_wdata[lfs_pkg::FLT_W-1:0];
        end
        if (wr_imask) begin
            nxt_st.int_mask = reg_wdata[lfs_pkg::INT_W-1:0];
        end

        f_tx  = nxt_st.flt[lfs_pkg::FLT_TX_POS];
        f_rx  = nxt_st.flt[lfs_pkg::FLT_RX_POS];
        f_cmn = nxt_st.flt[lfs_pkg::FLT_CMN_POS];

        // events: fault onset and loopback change
        evt = '0;
        evt[lfs_pkg::INT_TX_POS]  = f_tx && !st_ff.flt[lfs_pkg::FLT_TX_POS];
        evt[lfs_pkg::INT_RX_POS]  = f_rx && !st_ff.flt[lfs_pkg::FLT_RX_POS];
        evt[lfs_pkg::INT_CMN_POS] = f_cmn && !st_ff.flt[lfs_pkg::FLT_CMN_POS];
        evt[lfs_pkg::INT_LBM_POS] = nxt_st.lbm != st_ff.lbm;

        // write-one-to-clear, a new event wins
        clr = wr_istat ? reg_wdata[lfs_pkg::INT_W-1:0] : '0;
        nxt_st.int_stat = (st_ff.int_stat & ~clr) | evt;
        nxt_st.irq      = |(nxt_st.int_stat & nxt_st.int_mask);

        // RQ5: modulator relay from tx fault
        nxt_st.rly[0] = !f_tx;
        // RQ6: demodulator relay from rx fault
        nxt_st.rly[1] = !f_rx;
        // RQ7: common relay from common fault
        nxt_st.rly[2] = !f_cmn;
        // RQ8: modulator sink unless fault
        nxt_st.oc_oe[0] = !(f_tx || f_cmn);
        // RQ9: demodulator sink unless fault
        nxt_st.oc_oe[1] = !(f_rx || f_cmn);

        if (reg_rd) begin
            case (reg_addr)
                lfs_pkg::ADDR_CTRL: begin
                    nxt_st.rdata[lfs_pkg::CTRL_LBM_POS +: 2] = st_ff.lbm;
                end
                lfs_pkg::ADDR_FAULT: begin
                    nxt_st.rdata[lfs_pkg::FLT_W-1:0] = st_ff.flt;
                end
                lfs_pkg::ADDR_STATUS: begin
                    nxt_st.rdata[lfs_pkg::STS_LBM_POS +: 2] = st_ff.lbm;
                    nxt_st.rdata[lfs_pkg::STS_RLY_POS +: 3] = st_ff.rly;
                    nxt_st.rdata[lfs_pkg::STS_OC_POS +: 2]  = st_ff.oc_oe;
                    nxt_st.rdata[lfs_pkg::STS_PIN_POS +: 2] = {oc_demod_in, oc_mod_in};
                end
                lfs_pkg::ADDR_INT_STAT: begin
                    nxt_st.rdata[lfs_pkg::INT_W-1:0] = st_ff.int_stat;
                end
                lfs_pkg::ADDR_INT_MASK: begin
                    nxt_st.rdata[lfs_pkg::INT_W-1:0] = st_ff.int_mask;
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end
    end

    // RQ10: fault state held from reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= lfs_pkg::ST_RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // data path steering
    lfs_router #(
        .DW (DW)
    ) u_router (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .ce           (ce),
        .mode         (st_ff.lbm),
        .terr_tx_data (terr_tx_data),
        .sat_rx_data  (sat_rx_data),
        .bb_tx_data   (bb_tx_data),
        .terr_rx_data (terr_rx_data)
    );

    // ==========================================================
    // outputs
    assign reg_rdata    = st_ff.rdata;
    assign relay_mod    = st_ff.rly[0];
    assign relay_demod  = st_ff.rly[1];
    assign relay_common = st_ff.rly[2];
    assign oc_mod_out   = 1'b0;
    assign oc_mod_oe    = st_ff.oc_oe[0];
    assign oc_demod_out = 1'b0;
    assign oc_demod_oe  = st_ff.oc_oe[1];
    assign irq          = st_ff.irq;

endmodule : lfs_interface_module

`default_nettype wire

/* File: core/lfs_pkg.sv */
// Purpose: constants, types and shared decoding for the loopback and fault status block
// Assumes: one system clock, asynchronous active-high reset
// Notes:   register offsets are byte addresses on a 32-bit word port

package lfs_pkg;

    // ==========================================================
    // register bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_FAULT    = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    localparam logic [7:0]  ADDR_INT_STAT = 8'h0c;
    localparam logic [7:0]  ADDR_INT_MASK = 8'h10;

    // ==========================================================
    // field positions
    localparam int          CTRL_LBM_POS  = 0;
    localparam int          FLT_TX_POS    = 0;
    localparam int          FLT_RX_POS    = 1;
    localparam int          FLT_CMN_POS   = 2;
    localparam int          FLT_W         = 3;
    localparam int          STS_LBM_POS   = 0;
    localparam int          STS_RLY_POS   = 2;
    localparam int          STS_OC_POS    = 5;
    localparam int          STS_PIN_POS   = 7;
    localparam int          INT_TX_POS    = 0;
    localparam int          INT_RX_POS    = 1;
    localparam int          INT_CMN_POS   = 2;
    localparam int          INT_LBM_POS   = 3;
    localparam int          INT_W         = 4;

    // ==========================================================
    // reset values
    localparam logic [2:0]  FLT_RST       = 3'h7;
    localparam logic [3:0]  INT_STAT_RST  = 4'h0;
    localparam logic [3:0]  INT_MASK_RST  = 4'h0;
    localparam logic [2:0]  RLY_RST       = 3'h0;
    localparam logic [1:0]  OC_OE_RST     = 2'h0;

    // ==========================================================
    // loopback selection
    typedef enum logic [1:0] {
        LBM_NONE = 2'b00,
        LBM_TX   = 2'b01,
        LBM_RX   = 2'b10,
        LBM_BOTH = 2'b11
    } lfs_lbm_e;

    // ==========================================================
    // state of the register and status logic
    typedef struct packed {
        lfs_lbm_e            lbm;
        logic [FLT_W-1:0]    flt;
        logic [INT_W-1:0]    int_stat;
        logic [INT_W-1:0]    int_mask;
        logic [DATA_W-1:0]   rdata;
        logic                irq;
        logic [2:0]          rly;
        logic [1:0]          oc_oe;
    } lfs_state_s;

    localparam lfs_state_s  ST_RST = '{
        lbm:      LBM_NONE,
        flt:      FLT_RST,
        int_stat: INT_STAT_RST,
        int_mask: INT_MASK_RST,
        rdata:    32'h0000_0000,
        irq:      1'b0,
        rly:      RLY_RST,
        oc_oe:    OC_OE_RST
    };

    // ==========================================================
    // loopback decoding
    function automatic logic lbm_tx_loop(input lfs_lbm_e m);
        lbm_tx_loop = (m == LBM_TX) || (m == LBM_BOTH);
    endfunction : lbm_tx_loop

    function automatic logic lbm_rx_loop(input lfs_lbm_e m);
        lbm_rx_loop = (m == LBM_RX) || (m == LBM_BOTH);
    endfunction : lbm_rx_loop

endpackage : lfs_pkg

/* File: core/lfs_router.sv */
// Purpose: registered steering of terrestrial and satellite data for loopbacks
// Assumes: data inputs synchronous to clk_sys
// Notes:   one cycle of latency on both paths

`timescale 1ns/10ps
`default_nettype none

module lfs_router #(
    parameter int DW = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire lfs_pkg::lfs_lbm_e mode,
    input  wire logic [DW-1:0]    terr_tx_data,
    input  wire logic [DW-1:0]    sat_rx_data,
    output logic      [DW-1:0]    bb_tx_data,
    output logic      [DW-1:0]    terr_rx_data
);

    typedef struct packed {
        logic [DW-1:0] bb_tx;
        logic [DW-1:0] terr_rx;
    } lfs_rtr_s;

    lfs_rtr_s st_ff;
    lfs_rtr_s nxt_st;

    // ==========================================================
    // path selection
    always_comb begin
        nxt_st = st_ff;
        // RQ1: tx data to rx drivers
        // RQ3: both loops together
        nxt_st.terr_rx = lfs_pkg::lbm_tx_loop(mode) ? terr_tx_data : sat_rx_data;
        // RQ2: satellite data retransmitted
        // RQ3: both loops together
        nxt_st.bb_tx   = lfs_pkg::lbm_rx_loop(mode) ? sat_rx_data : terr_tx_data;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign bb_tx_data   = st_ff.bb_tx;
    assign terr_rx_data = st_ff.terr_rx;

endmodule : lfs_router

`default_nettype wire

/* File: tb/lfs_assertions.sv */
// Purpose: port checks of loopback routing and fault outputs
// Assumes: mode and fault writes tracked from the register port
// Notes:   bound into the top module
`timescale 1ns/10ps
`default_nettype none
module lfs_assertions #(
    parameter int DW = 1
) (
    input wire logic                        clk_sys,
    input wire logic                        rst,
    input wire logic                        ce,
    input wire logic [lfs_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [lfs_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic [DW-1:0]               terr_tx_data,
    input wire logic [DW-1:0]               sat_rx_data,
    input wire logic [DW-1:0]               bb_tx_data,
    input wire logic [DW-1:0]               terr_rx_data,
    input wire logic                        relay_mod,
    input wire logic                        relay_demod,
    input wire logic                        relay_common,
    input wire logic                        oc_mod_out,
    input wire logic                        oc_mod_oe,
    input wire logic                        oc_demod_out,
    input wire logic                        oc_demod_oe,
    input wire logic                        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ==========================================================
    // tracked mode and first fault write
    lfs_pkg::lfs_lbm_e mode_ff;
    logic              clr_ff;
    logic              fw;
    assign fw = ce && reg_wr && (reg_addr == lfs_pkg::ADDR_FAULT);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_ff <= lfs_pkg::LBM_NONE;
            clr_ff  <= 1'b0;
        end else begin
            if (ce && reg_wr && (reg_addr == lfs_pkg::ADDR_CTRL))
                mode_ff <= lfs_pkg::lfs_lbm_e'(reg_wdata[1:0]);
            if (fw)
                clr_ff <= 1'b1;
        end
    end
    a_tx_loop: assert property (ce && mode_ff[0] |=> terr_rx_data == $past(terr_tx_data))
        else $error("tx loopback data wrong");
    a_rx_loop: assert property (ce && mode_ff[1] |=> bb_tx_data == $past(sat_rx_data))
        else $error("rx loopback data wrong");
    a_both_loop: assert property (ce && mode_ff == lfs_pkg::LBM_BOTH |=>
        {terr_rx_data, bb_tx_data} == $past({terr_tx_data, sat_rx_data}))
        else $error("combined loopback wrong");
    a_relay_hold: assert property (!fw |=> $stable({relay_mod, relay_demod, relay_common}))
        else $error("relay changed without write");
    a_mod_relay: assert property (fw |=> relay_mod == !$past(reg_wdata[0]))
        else $error("modulator relay wrong");
    a_demod_relay: assert property (fw |=> relay_demod == !$past(reg_wdata[1]))
        else $error("demodulator relay wrong");
    a_common_relay: assert property (fw |=> relay_common == !$past(reg_wdata[2]))
        else $error("common relay wrong");
    a_mod_line: assert property (fw |=> !oc_mod_out &&
        oc_mod_oe == !($past(reg_wdata[0]) || $past(reg_wdata[2])))
        else $error("modulator line wrong");
    a_demod_line: assert property (fw |=> !oc_demod_out &&
        oc_demod_oe == !($past(reg_wdata[1]) || $past(reg_wdata[2])))
        else $error("demodulator line wrong");
    a_reset_fault: assert property (!clr_ff |->
        {relay_mod, relay_demod, relay_common, oc_mod_oe, oc_demod_oe} == 5'h00)
        else $error("fault state not held");
    c_both: cover property (ce && mode_ff == lfs_pkg::LBM_BOTH);
    c_clear: cover property (fw && reg_wdata[2:0] == 3'h0);
    c_irq: cover property (irq);
endmodule : lfs_assertions
bind lfs_interface_module lfs_assertions #(.DW(DW)) u_chk (.clk_sys, .rst, .ce, .reg_addr,
    .reg_wdata, .reg_wr, .terr_tx_data, .sat_rx_data, .bb_tx_data, .terr_rx_data, .relay_mod,
    .relay_demod, .relay_common, .oc_mod_out, .oc_mod_oe, .oc_demod_out, .oc_demod_oe, .irq);
`default_nettype wire

/* File: tb/lfs_partner.sv */
// Purpose: far-side data sources and open-collector pull-ups
// Assumes: data changes every cycle so stale routing shows
// Notes:   released pins read high through the pull-up
`timescale 1ns/10ps
`default_nettype none
module lfs_partner #(
    parameter int DW = 4
) (
    input  wire logic          clk_sys,
    input  wire logic          mod_oe,
    input  wire logic          demod_oe,
    output logic      [DW-1:0] terr_tx_data,
    output logic      [DW-1:0] sat_rx_data,
    output logic               mod_pin,
    output logic               demod_pin
);
    // one process drives both sources, so each value has a single driver
    initial begin
        terr_tx_data = '0;
        sat_rx_data  = DW'(5);
        forever begin
            @(posedge clk_sys);
            terr_tx_data <= terr_tx_data + DW'(1);
            sat_rx_data  <= sat_rx_data - DW'(3);
        end
    end
    assign mod_pin   = mod_oe ? 1'b0 : 1'b1;
    assign demod_pin = demod_oe ? 1'b0 : 1'b1;
endmodule : lfs_partner
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench of routing, relays, lines and interrupt
// Assumes: register writes take effect one cycle after the strobe
// Notes:   data width 4 so routing sources differ
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  terr_tx, sat_rx, bb_tx, terr_rx, p_terr, p_sat;
    logic        r_mod, r_demod, r_cmn, m_out, m_oe, d_out, d_oe, irq, m_pin, d_pin;
    int          err_count = 0;
    int          compares = 0;
    int          cyc = 0;
    initial forever #4 clk_sys = ~clk_sys;
    lfs_interface_module #(.DW(4)) uut (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .terr_tx_data(terr_tx), .sat_rx_data(sat_rx), .bb_tx_data(bb_tx),
        .terr_rx_data(terr_rx), .relay_mod(r_mod), .relay_demod(r_demod), .relay_common(r_cmn),
        .oc_mod_in(m_pin), .oc_mod_out(m_out), .oc_mod_oe(m_oe), .oc_demod_in(d_pin),
        .oc_demod_out(d_out), .oc_demod_oe(d_oe), .irq);
    lfs_partner #(.DW(4)) u_far (.clk_sys, .mod_oe(m_oe), .demod_oe(d_oe),
        .terr_tx_data(terr_tx), .sat_rx_data(sat_rx), .mod_pin(m_pin), .demod_pin(d_pin));
    always @(posedge clk_sys) begin
        p_terr <= terr_tx;
        p_sat  <= sat_rx;
        cyc    <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd
    task automatic t_reset();
        #1;
        `CHK({r_mod, r_demod, r_cmn, m_oe, d_oe}, 5'h00)
        rd(lfs_pkg::ADDR_FAULT, 32'h7);
        rd(lfs_pkg::ADDR_STATUS, 32'h180);
    endtask : t_reset
    task automatic t_loop();
        for (int m = 0; m < 4; m++) begin
            wr(lfs_pkg::ADDR_CTRL, 32'(m));
            @(posedge clk_sys);
            #1;
            `CHK(terr_rx, m[0] ? p_terr : p_sat)
            `CHK(bb_tx, m[1] ? p_sat : p_terr)
        end
        // loopback change event, fault word untouched since reset
        rd(lfs_pkg::ADDR_INT_STAT, 32'h8);
    endtask : t_loop
    task automatic t_fault();
        for (int w = 0; w < 8; w++) begin
            wr(lfs_pkg::ADDR_FAULT, 32'(w));
            `CHK({r_mod, r_demod, r_cmn}, ~{w[0], w[1], w[2]})
            `CHK({m_oe, m_out}, {!(w[0] || w[2]), 1'b0})
            `CHK({d_oe, d_out}, {!(w[1] || w[2]), 1'b0})
            rd(lfs_pkg::ADDR_STATUS, 32'({w[1] | w[2], w[0] | w[2], !(w[1] | w[2]),
                !(w[0] | w[2]), ~w[2], ~w[1], ~w[0], 2'h3}));
        end
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(lfs_pkg::ADDR_FAULT, 32'h0);
        `CHK({r_mod, r_demod, r_cmn}, 3'h0)
        @(posedge clk_sys);
        ce <= 1'b1;
    endtask : t_fault
    task automatic t_irq();
        wr(lfs_pkg::ADDR_FAULT, 32'h0);
        wr(lfs_pkg::ADDR_INT_STAT, 32'hf);
        wr(lfs_pkg::ADDR_INT_MASK, 32'h1);
        wr(lfs_pkg::ADDR_FAULT, 32'h1);
        @(posedge clk_sys);
        #1;
        `CHK(irq, 1'b1)
        rd(lfs_pkg::ADDR_INT_STAT, 32'h1);
        wr(lfs_pkg::ADDR_INT_STAT, 32'h1);
        wr(lfs_pkg::ADDR_FAULT, 32'h2);
        @(posedge clk_sys);
        #1;
        `CHK(irq, 1'b0)
        rd(lfs_pkg::ADDR_INT_STAT, 32'h2);
        // common fault onset sets its own bit
        wr(lfs_pkg::ADDR_FAULT, 32'h4);
        rd(lfs_pkg::ADDR_INT_STAT, 32'h6);
        rd(8'h20, 32'h0);
    endtask : t_irq
    task automatic conclude();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_loop();
        t_fault();
        t_irq();
        conclude();
    end
endmodule : testbench
`default_nettype wire
